// *** src/cbus_pkg.sv ***
// Constants and command kinds shared by both ends of the command bus.
// Assumes one common clock and a synchronous active-high reset.
package cbus_pkg;
    localparam int BUS_W = 24;
    localparam int OP_W = 4;
    localparam int PAY_W = BUS_W - OP_W;
    localparam int CFG_W = 2;
    localparam logic [BUS_W-1:0] NOP_WORD = 24'hffffff;
    // Bridge drive length after a win
    localparam logic [1:0] OWN_CYCLES = 2'h2;
    // Cycles from a load to the next data-bus command
    localparam logic [1:0] LOAD_GAP = 2'h3;
    // Cycles from a load to its good-data indication
    localparam int GOOD_DELAY = 2;
    // Words that follow the upstream CSR-write header
    localparam logic [2:0] CSR_WORDS = 3'h4;

    // All-ones opcode stays reserved for the idle bus
    typedef enum logic [OP_W-1:0] {
        OP_LOAD_DMA = 4'h0,
        OP_LOAD_SG  = 4'h1,
        OP_LOAD_P2P = 4'h2,
        OP_RMW_DOWN = 4'h3,
        OP_RMW_UP   = 4'h4,
        OP_CSR_WR   = 4'h5,
        OP_CSR_UP   = 4'h6,
        OP_P2P_WR   = 4'h7,
        OP_REQ      = 4'h8,
        OP_NOP      = 4'hf
    } op_t;

    function automatic op_t opOf(logic [BUS_W-1:0] w);
        return op_t'(w[BUS_W-1 -: OP_W]);
    endfunction : opOf

    function automatic logic isLoad(op_t op);
        return op inside {OP_LOAD_DMA, OP_LOAD_SG, OP_LOAD_P2P, OP_RMW_DOWN};
    endfunction : isLoad

    function automatic logic needsGood(op_t op);
        return op inside {OP_LOAD_DMA, OP_LOAD_SG, OP_LOAD_P2P};
    endfunction : needsGood

    function automatic logic isHeld(op_t op);
        return op inside {OP_RMW_DOWN, OP_CSR_WR};
    endfunction : isHeld
endpackage : cbus_pkg

// *** src/cbus_if.sv ***
// Shared open-drain command bus between the controller and two bridges.
// Assumes external pullups, modelled here by a wired-AND resolution.
`timescale 1ns/1ns
interface cbus_if;
    logic [cbus_pkg::BUS_W-1:0]      ctlOut;  // Controller level, low
    logic [cbus_pkg::BUS_W-1:0]      ctlOe;   // Controller pulls bit
    wire  [1:0][cbus_pkg::BUS_W-1:0] brOut;   // Bridge levels, low
    wire  [1:0][cbus_pkg::BUS_W-1:0] brOe;    // Bridge pulls bit
    wire  [1:0]                      reqN;    // Bridge requests
    logic                            claimN;  // Controller claim
    logic [1:0]                      sel;     // Target selects
    logic [1:0]                      good;    // Good-data per bridge
    logic [cbus_pkg::BUS_W-1:0]      bus;     // Resolved bus level

    // Any enabled low driver pulls the line; otherwise pullup wins
    assign bus = ~(ctlOe & ~ctlOut) & ~(brOe[0] & ~brOut[0])
               & ~(brOe[1] & ~brOut[1]);

    modport ctl (input bus, reqN,
                 output ctlOut, ctlOe, claimN, sel, good);
    modport bridge (input bus, claimN, sel, good,
                    output brOut, brOe, reqN);
endinterface : cbus_if

// *** src/cbus_bridge.sv ***
// Bridge end of the command bus: requests, two-cycle ownership,
// selected decode, held answers and good-data checking.
// Assumes a cbus_if shared with the controller on the same core_clk.
`timescale 1ns/1ns
module cbus_bridge #(
    parameter bit BRIDGE_IDX = 1'b0          // Index strap
) (
    input  wire logic                   core_clk,  // 100 MHz clock
    input  wire logic                   srst,      // Synchronous reset
    cbus_if.bridge                      bus,       // Shared bus
    input  wire logic                   reqValid,  // Two words to send
    input  wire logic [47:0]            reqWords,  // Low word first
    output logic                        reqTaken,  // Second word out
    output logic                        rxValid,   // Own command seen
    output logic [cbus_pkg::BUS_W-1:0]  rxWord,    // That command
    output logic                        peerWrite, // Peer write seen
    output logic                        loadDone,  // Load verdict
    output logic                        loadGood,  // Data is good
    output logic [1:0]                  cfgWidth,  // Latched straps
    input  wire logic                   heldReady, // Answer may go
    input  wire logic [95:0]            heldData,  // CSR words
    output logic                        heldDone   // Held answer sent
);
    typedef enum logic [2:0] {
        B_IDLE = 3'b000,
        B_REQ  = 3'b001,
        B_OWN1 = 3'b011,
        B_OWN2 = 3'b010,
        B_WAIT = 3'b110,
        B_HELD = 3'b111
    } bstate_t;

    localparam bit OTHER = ~BRIDGE_IDX;

    bstate_t                    state_q, state_d;
    logic [1:0]                 own_q, own_d;
    logic                       lastMe_q, anyWin, iWin, mySel, otherSel;
    logic                       heldSeen, heldLast, rstPrev_q;
    cbus_pkg::op_t              busOp, heldOp_q;
    logic [2:0]                 idx_q, idx_d;
    logic [cbus_pkg::BUS_W-1:0] word_d, oe_q, rxWord_q;
    logic                       reqN_q, taken_q, rxValid_q, peer_q;
    logic [cbus_pkg::GOOD_DELAY-1:0] lp_q;
    logic                       done_q, good_q, heldDone_q;
    logic [1:0]                 cfg_q;

    assign busOp = cbus_pkg::opOf(bus.bus);
    assign mySel = !bus.claimN && bus.sel[BRIDGE_IDX];
    assign otherSel = !bus.claimN && bus.sel[OTHER];
    assign heldSeen = mySel && cbus_pkg::isHeld(busOp);

    // Same arbitration view as every other end
    assign anyWin = (own_q == 2'h0) && bus.claimN && (bus.reqN != 2'b11);
    assign iWin = anyWin && !bus.reqN[BRIDGE_IDX]
               && (bus.reqN[OTHER] || !lastMe_q);
    always_comb begin
        if (own_q != 2'h0)
            own_d = own_q - 2'h1;
        else if (anyWin)
            own_d = cbus_pkg::OWN_CYCLES;
        else
            own_d = 2'h0;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            own_q <= 2'h0;
            lastMe_q <= (BRIDGE_IDX != 1'b0);
        end else begin
            own_q <= own_d;
            if (anyWin)
                lastMe_q <= iWin;
        end
    end

    // Held answer: header, then for a CSR write its four words low first
    assign heldLast = (heldOp_q == cbus_pkg::OP_RMW_DOWN) ?
                      (idx_q == 3'h0) : (idx_q == cbus_pkg::CSR_WORDS);
    always_comb begin
        state_d = state_q;
        idx_d = idx_q;
        case (state_q)
            B_IDLE, B_REQ: begin
                if (heldSeen)
                    state_d = B_WAIT;
                else if (iWin && state_q == B_REQ)
                    state_d = B_OWN1;
                else if (reqValid)
                    state_d = B_REQ;
            end
            B_OWN1: state_d = B_OWN2;
            B_OWN2: state_d = B_IDLE;
            B_WAIT: begin
                idx_d = 3'h0;
                if (heldReady)
                    state_d = B_HELD;
            end
            B_HELD: begin
                if (heldLast)
                    state_d = B_IDLE;
                else
                    idx_d = idx_q + 3'h1;
            end
            default: state_d = B_IDLE;
        endcase
    end

    // Word placed on the bus next cycle
    always_comb begin
        word_d = cbus_pkg::NOP_WORD;
        case (state_d)
            B_OWN1: word_d = reqWords[23:0];
            B_OWN2: word_d = reqWords[47:24];
            B_HELD: begin
                if (idx_d == 3'h0)
                    word_d = {(heldOp_q == cbus_pkg::OP_RMW_DOWN) ?
                              cbus_pkg::OP_RMW_UP : cbus_pkg::OP_CSR_UP,
                              {cbus_pkg::PAY_W{1'b0}}};
                else
                    word_d = heldData[24*(idx_d-3'h1) +: 24];
            end
            default: word_d = cbus_pkg::NOP_WORD;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= B_IDLE;
            idx_q <= 3'h0;
            heldOp_q <= cbus_pkg::OP_NOP;
            oe_q <= '0;
            reqN_q <= 1'b0;
        end else begin
            state_q <= state_d;
            idx_q <= idx_d;
            if (heldSeen)
                heldOp_q <= busOp;
            oe_q <= ~word_d;
            reqN_q <= (state_d != B_REQ);
        end
    end

    // Decode, peer watch, good-data verdict and strap capture
    always_ff @(posedge core_clk) begin
        rstPrev_q <= srst;
        if (srst) begin
            {taken_q, rxValid_q, peer_q, done_q, good_q} <= 5'h00;
            heldDone_q <= 1'b0;
            lp_q <= '0;
            rxWord_q <= cbus_pkg::NOP_WORD;
        end else begin
            taken_q <= (state_d == B_OWN2);
            rxValid_q <= mySel && (bus.bus != cbus_pkg::NOP_WORD);
            rxWord_q <= bus.bus;
            peer_q <= otherSel && (busOp == cbus_pkg::OP_P2P_WR);
            lp_q <= {lp_q[cbus_pkg::GOOD_DELAY-2:0],
                     mySel && cbus_pkg::needsGood(busOp)};
            done_q <= lp_q[cbus_pkg::GOOD_DELAY-1];
            good_q <= bus.good[BRIDGE_IDX];
            heldDone_q <= (state_q == B_HELD) && heldLast;
        end
        if (srst)
            cfg_q <= 2'b00;
        else if (rstPrev_q)
            cfg_q <= bus.bus[cbus_pkg::CFG_W-1:0];
    end

    assign bus.brOut[BRIDGE_IDX] = '0;  // Open drain only pulls low
    assign bus.brOe[BRIDGE_IDX] = oe_q;
    assign bus.reqN[BRIDGE_IDX] = reqN_q;
    assign reqTaken = taken_q;
    assign rxValid = rxValid_q;
    assign rxWord = rxWord_q;
    assign peerWrite = peer_q;
    assign loadDone = done_q;
    assign loadGood = good_q;
    assign cfgWidth = cfg_q;
    assign heldDone = heldDone_q;
endmodule : cbus_bridge

// *** src/cbus_ctl.sv ***
// Controller end of the command bus: claim, target selects, held
// grants for read-modify-write and CSR write, and good-data timing.
// Assumes a cbus_if shared with the bridges on the same core_clk.
`timescale 1ns/1ns
module cbus_ctl (
    input  wire logic                   core_clk,   // 100 MHz clock
    input  wire logic                   srst,       // Synchronous reset
    cbus_if.ctl                         bus,        // Shared bus
    input  wire logic [1:0]             cfgStraps,  // Check-bit width
    input  wire logic                   cmdValid,   // Command offered
    input  wire cbus_pkg::op_t          cmdOp,      // Command kind
    input  wire logic [19:0]            cmdPayload, // Command body
    input  wire logic                   cmdTarget,  // Target bridge
    input  wire logic                   cmdGood,    // Load data good
    output logic                        cmdReady,   // Taken if valid
    output logic                        rxValid,    // Bridge word seen
    output logic [cbus_pkg::BUS_W-1:0]  rxWord,     // That word
    output logic                        csrDone,    // CSR echo ended
    output logic [1:0]                  present     // Bridges found
);
    typedef enum logic [1:0] {
        C_IDLE  = 2'b00,
        C_CLAIM = 2'b01,
        C_DRIVE = 2'b11,
        C_HOLD  = 2'b10
    } cstate_t;

    cstate_t                    state_q, state_d;
    logic [1:0]                 own_q, own_d;
    logic                       lastOwner_q;
    logic                       bridgeWins, winner;
    logic [1:0]                 gap_q, gap_d;
    logic                       accept, holdEnd, ready_d;
    cbus_pkg::op_t              busOp, lastOp_q;
    logic [2:0]                 words_q;
    logic                       csrActive_q;
    logic [cbus_pkg::BUS_W-1:0] oe_q, rxWord_q;
    logic                       claimN_q, ready_q, rstPrev_q;
    logic [1:0]                 sel_q, present_q, tgtBits;
    logic [cbus_pkg::GOOD_DELAY:0][1:0] gdPipe_q;
    logic                       rxValid_q, csrDone_q;

    assign busOp = cbus_pkg::opOf(bus.bus);
    assign accept = ready_q && cmdValid;
    assign tgtBits = cmdTarget ? 2'b10 : 2'b01;

    // Arbitration view; every end keeps an identical copy
    assign bridgeWins = (own_q == 2'h0) && bus.claimN
                     && (bus.reqN != 2'b11);
    assign winner = (bus.reqN == 2'b10) ? 1'b0 :
                    (bus.reqN == 2'b01) ? 1'b1 :
                    ~lastOwner_q;

    // Non-arbitration cycles left after a bridge win
    always_comb begin
        if (own_q != 2'h0)
            own_d = own_q - 2'h1;
        else if (bridgeWins)
            own_d = cbus_pkg::OWN_CYCLES;
        else
            own_d = 2'h0;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            own_q <= 2'h0;
            lastOwner_q <= 1'b1;
        end else begin
            own_q <= own_d;
            if (bridgeWins)
                lastOwner_q <= winner;
        end
    end

    // Spacing after loads; also stalls other commands for simplicity
    always_comb begin
        if (accept && cbus_pkg::isLoad(cmdOp))
            gap_d = cbus_pkg::LOAD_GAP - 2'h1;
        else if (gap_q != 2'h0)
            gap_d = gap_q - 2'h1;
        else
            gap_d = 2'h0;
    end

    // Held grant ends on the bridge's upstream answer
    assign holdEnd = (state_q == C_HOLD) &&
        ((lastOp_q == cbus_pkg::OP_RMW_DOWN &&
          busOp == cbus_pkg::OP_RMW_UP) ||
         (csrActive_q && words_q == 3'h1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            C_IDLE: begin
                // Claim only where the next cycle arbitrates
                if (cmdValid && own_d == 2'h0)
                    state_d = C_CLAIM;
            end
            C_CLAIM: begin
                if (accept)
                    state_d = C_DRIVE;
                else if (!cmdValid)
                    state_d = C_IDLE;
            end
            C_DRIVE: begin
                if (cbus_pkg::isHeld(lastOp_q))
                    state_d = C_HOLD;
                else if (accept)
                    state_d = C_DRIVE;
                else if (cmdValid)
                    state_d = C_CLAIM;
                else
                    state_d = C_IDLE;
            end
            C_HOLD: begin
                // Claim kept, so the cycle after is a turnaround
                if (holdEnd)
                    state_d = cmdValid ? C_CLAIM : C_IDLE;
            end
            default: state_d = C_IDLE;
        endcase
    end

    // Ready means a valid command is taken at this cycle's edge
    assign ready_d = (gap_d == 2'h0) &&
        (state_d == C_CLAIM ||
         (state_d == C_DRIVE && !cbus_pkg::isHeld(cmdOp)));

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= C_IDLE;
            gap_q <= 2'h0;
            ready_q <= 1'b0;
            lastOp_q <= cbus_pkg::OP_NOP;
        end else begin
            state_q <= state_d;
            gap_q <= gap_d;
            ready_q <= ready_d;
            if (accept)
                lastOp_q <= cmdOp;
        end
    end

    // Bus drive, selects and claim
    always_ff @(posedge core_clk) begin
        if (srst) begin
            oe_q <= {{(cbus_pkg::BUS_W-cbus_pkg::CFG_W){1'b0}},
                     ~cfgStraps};
            sel_q <= 2'b00;
            claimN_q <= 1'b0;
        end else begin
            if (accept) begin
                oe_q <= ~{cmdOp, cmdPayload};
                sel_q <= tgtBits;
            end else begin
                oe_q <= '0;
                sel_q <= 2'b00;
            end
            claimN_q <= (state_d == C_IDLE);
        end
    end

    // Good-data follows a speculative load by a fixed delay
    always_ff @(posedge core_clk) begin
        if (srst)
            gdPipe_q <= '0;
        else
            gdPipe_q <= {gdPipe_q[cbus_pkg::GOOD_DELAY-1:0],
                         (accept && cmdGood &&
                          cbus_pkg::needsGood(cmdOp)) ?
                         tgtBits : 2'b00};
    end

    // Counting the four CSR words behind the upstream header
    always_ff @(posedge core_clk) begin
        if (srst) begin
            csrActive_q <= 1'b0;
            words_q <= 3'h0;
        end else if (state_q == C_HOLD && !csrActive_q &&
                     lastOp_q == cbus_pkg::OP_CSR_WR &&
                     busOp == cbus_pkg::OP_CSR_UP) begin
            csrActive_q <= 1'b1;
            words_q <= cbus_pkg::CSR_WORDS;
        end else if (csrActive_q) begin
            words_q <= words_q - 3'h1;
            if (words_q == 3'h1)
                csrActive_q <= 1'b0;
        end
    end

    // Received words; an idle all-ones bus is no command
    always_ff @(posedge core_clk) begin
        if (srst) begin
            rxValid_q <= 1'b0;
            rxWord_q <= cbus_pkg::NOP_WORD;
            csrDone_q <= 1'b0;
        end else begin
            rxValid_q <= (oe_q == '0) && (csrActive_q ||
                         bus.bus != cbus_pkg::NOP_WORD);
            rxWord_q <= bus.bus;
            csrDone_q <= holdEnd &&
                         (lastOp_q == cbus_pkg::OP_CSR_WR);
        end
    end

    // Presence: requests still asserted from reset at release
    always_ff @(posedge core_clk) begin
        rstPrev_q <= srst;
        if (srst)
            present_q <= 2'b00;
        else if (rstPrev_q)
            present_q <= ~bus.reqN;
    end

    assign bus.ctlOut = '0;  // Open drain only ever pulls low
    assign bus.ctlOe = oe_q;
    assign bus.claimN = claimN_q;
    assign bus.sel = sel_q;
    assign bus.good = gdPipe_q[cbus_pkg::GOOD_DELAY];
    assign cmdReady = ready_q;
    assign rxValid = rxValid_q;
    assign rxWord = rxWord_q;
    assign csrDone = csrDone_q;
    assign present = present_q;
endmodule : cbus_ctl

// *** test/cbus_asserts.sv ***
// Timing checks on the shared command bus, seen from outside both ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module cbus_asserts (
    input wire logic             core_clk, // Clock
    input wire logic             srst,     // Reset
    input wire logic [23:0]      bus,      // Resolved bus
    input wire logic [23:0]      ctlOe,    // Controller pulls
    input wire logic [1:0][23:0] brOe,     // Bridge pulls
    input wire logic [1:0]       reqN,     // Bridge requests
    input wire logic             claimN,   // Controller claim
    input wire logic [1:0]       sel,      // Target selects
    input wire logic [1:0]       good      // Good-data
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    // Which bridge pulls any line
    wire [1:0] brOn = {|brOe[1], |brOe[0]};

    AST_SEL: assert property (
        |sel |-> !claimN && |ctlOe && $onehot(sel))
        else $error("select without a claimed single drive");
    AST_CLAIM: assert property (|ctlOe |-> !claimN)
        else $error("controller drives without claim");
    AST_EXCL: assert property (!(brOn[0] && brOn[1]))
        else $error("both bridges drive at once");
    AST_CTL_TURN: assert property (|ctlOe |=> brOn == 2'h0)
        else $error("bridge drives right after controller");
    AST_BR_TURN: assert property (
        brOn != 2'h0 ##1 brOn == 2'h0 |-> ctlOe == 24'h0)
        else $error("controller drives right after bridge");
    AST_OWN: assert property (
        $rose(brOn[0]) && $past(claimN) && !$past(reqN[0])
        |-> ##1 brOn[0] ##1 !brOn[0])
        else $error("bridge ownership not two cycles");
    AST_OWN1: assert property (
        $rose(brOn[1]) && $past(claimN) && !$past(reqN[1])
        |-> ##1 brOn[1] ##1 !brOn[1])
        else $error("second bridge ownership not two cycles");
    // Reset behaviour is checked while reset is high, so no disable here
    AST_RST: assert property (disable iff (1'b0) srst |=>
        !claimN && reqN == 2'h0 && sel == 2'h0)
        else $error("claim and requests not asserted in reset");
    AST_GOOD: assert property (|good |->
        $past(sel, 2) == good && $past(bus[23:20], 2) <= 4'h2)
        else $error("good-data not two cycles after a load");
    AST_GAP: assert property (
        |sel && bus[23:20] <= 4'h2 |=> (sel == 2'h0)[*2])
        else $error("command too soon after a load");
endmodule : cbus_asserts

// *** test/test_shared_command_bus_arbitration.sv ***
// Self-checking bench joining the controller and two bridges.
// Assumes the bus interface resolves the wired-AND itself.
`timescale 1ns/1ns
module test_shared_command_bus_arbitration;
    logic          core_clk = 1'b0;
    logic          srst = 1'b1;
    logic [1:0]    cfgStraps;
    logic          cmdValid = 1'b0, cmdTarget = 1'b0, cmdGood = 1'b0;
    cbus_pkg::op_t cmdOp = cbus_pkg::OP_NOP;
    logic [19:0]   cmdPayload = 20'h0;
    logic [1:0]    reqValid = 2'h0;
    logic [47:0]   reqWords [2];
    logic [95:0]   heldData;
    logic          cmdReady, cRxV, csrDone;
    logic [23:0]   cRx;
    logic [1:0]    present, reqTaken, bRxV, peerW, lDone, lGood, hDone;
    logic [1:0]    heldRdy = 2'h0;
    logic [23:0]   bRx [2];
    logic [1:0]    cfgW [2];
    logic [24:0]   brQ[$], ctlQ[$], ldQ[$];
    int            failures = 0, nChecks = 0, nPeer = 0, nPeerSeen = 0;
    int            nCsr = 0, nHeld = 0;

    // 100 MHz clock
    always #5 core_clk = ~core_clk;

    // Bridges stall their held answers at random, so waits get exercised
    always @(posedge core_clk) #1 heldRdy = 2'($urandom);

    cbus_if cb ();
    cbus_ctl i_cbus_ctl (.core_clk(core_clk), .srst(srst), .bus(cb),
        .cfgStraps(cfgStraps), .cmdValid(cmdValid), .cmdOp(cmdOp),
        .cmdPayload(cmdPayload), .cmdTarget(cmdTarget), .cmdGood(cmdGood),
        .cmdReady(cmdReady), .rxValid(cRxV), .rxWord(cRx),
        .csrDone(csrDone), .present(present));
    for (genvar b = 0; b < 2; b++) begin : g_br
        cbus_bridge #(.BRIDGE_IDX(b == 1)) i_cbus_bridge (
            .core_clk(core_clk), .srst(srst), .bus(cb),
            .reqValid(reqValid[b]), .reqWords(reqWords[b]),
            .reqTaken(reqTaken[b]), .rxValid(bRxV[b]), .rxWord(bRx[b]),
            .peerWrite(peerW[b]), .loadDone(lDone[b]), .loadGood(lGood[b]),
            .cfgWidth(cfgW[b]), .heldReady(heldRdy[b]), .heldData(heldData),
            .heldDone(hDone[b]));
    end
    cbus_asserts i_cbus_asserts (.core_clk(core_clk), .srst(srst),
        .bus(cb.bus), .ctlOe(cb.ctlOe), .brOe(cb.brOe), .reqN(cb.reqN),
        .claimN(cb.claimN), .sel(cb.sel), .good(cb.good));

    task automatic chk(input logic [24:0] e, input logic [24:0] a);
        nChecks++;
        if (e !== a) begin
            failures++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : chk

    task automatic conclude();
        $display("checks=%0d failures=%0d", nChecks, failures);
        if (failures == 0 && nChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    // Offer one command and note what each end should see
    task automatic sendCmd(input cbus_pkg::op_t op, input logic t);
        int n;
        n = 0;
        @(posedge core_clk);
        #1 cmdOp = op;
        cmdTarget = t;
        cmdGood = 1'($urandom);
        cmdPayload = 20'($urandom);
        cmdValid = 1'b1;
        brQ.push_back({t, op, cmdPayload});
        if (op <= cbus_pkg::OP_LOAD_P2P) ldQ.push_back({t, cmdGood});
        if (op == cbus_pkg::OP_P2P_WR) nPeer++;
        if (op == cbus_pkg::OP_RMW_DOWN) ctlQ.push_back(25'h0400000);
        if (op == cbus_pkg::OP_CSR_WR) begin
            ctlQ.push_back(25'h0600000);
            for (int k = 0; k < 4; k++)
                ctlQ.push_back({1'b0, heldData[24*k +: 24]});
        end
        do @(posedge core_clk); while (cmdReady !== 1'b1 && n++ < 100);
        #1 cmdValid = 1'b0;
        // A limit that runs out counts as a mismatch
        if (n > 100) failures++;
    endtask : sendCmd

    // Hold a two-word request until the bridge reports it sent
    task automatic bridgeReq(input int b);
        int n;
        n = 0;
        reqValid[b] = 1'b1;
        do @(posedge core_clk); while (reqTaken[b] !== 1'b1 && n++ < 100);
        #1 reqValid[b] = 1'b0;
        if (n > 100) failures++;
    endtask : bridgeReq

    // Fresh random words for a bridge, noted in the order they will land
    task automatic noteReq(input int b);
        reqWords[b] = {4'h8, 20'($urandom), 4'h8, 20'($urandom)};
        ctlQ.push_back({1'b0, reqWords[b][23:0]});
        ctlQ.push_back({1'b0, reqWords[b][47:24]});
    endtask : noteReq

    // Sample settled outputs mid-cycle, oldest note first; X counts too
    always @(negedge core_clk) begin
        if (cRxV !== 1'b0)
            chk(ctlQ.pop_front(), {1'b0, cRx});
        if (csrDone !== 1'b0) nCsr++;
        for (int b = 0; b < 2; b++) begin
            if (bRxV[b] !== 1'b0)
                chk(brQ.pop_front(), {b[0], bRx[b]});
            if (lDone[b] !== 1'b0)
                chk(ldQ.pop_front(), {b[0], lGood[b]});
            if (peerW[b] !== 1'b0) nPeerSeen++;
            if (hDone[b] !== 1'b0) nHeld++;
        end
    end

    // Hang guard, well past the expected run length
    initial begin
        #100000 failures++;
        conclude();
    end

    initial begin
        void'($urandom(15));
        cfgStraps = 2'($urandom);
        heldData = {$urandom, $urandom, $urandom};
        reqWords[0] = 48'h0;
        reqWords[1] = 48'h0;
        repeat (16) @(posedge core_clk);
        #1 srst = 1'b0;
        repeat (3) @(posedge core_clk);
        for (int b = 0; b < 2; b++) chk(cfgStraps, cfgW[b]);
        chk(2'h3, present);
        $display("test reset done");
        for (int k = 0; k < 6; k++)
            sendCmd(cbus_pkg::op_t'(k < 3 ? k : 7), 1'($urandom));
        repeat (10) @(posedge core_clk);
        $display("test commands done");
        // Ties: bridge 0 first; after a lone bridge 0 win, bridge 1 first
        for (int r = 0; r < 2; r++) begin
            #1;
            if (r == 1) begin
                noteReq(0);
                bridgeReq(0);
                repeat (3) @(posedge core_clk);
                #1;
            end
            noteReq(r);
            noteReq(1 - r);
            fork
                bridgeReq(0);
                bridgeReq(1);
            join
            repeat (3) @(posedge core_clk);
        end
        $display("test requests done");
        sendCmd(cbus_pkg::OP_CSR_WR, 1'b1);
        sendCmd(cbus_pkg::OP_RMW_DOWN, 1'b0);
        repeat (40) @(posedge core_clk);
        chk(nPeer, nPeerSeen);
        chk(1, nCsr);
        chk(2, nHeld);
        chk(0, ctlQ.size() + brQ.size() + ldQ.size());
        $display("test held grants done");
        conclude();
    end
endmodule : test_shared_command_bus_arbitration
